// *** cee_pkg.sv ***
package cee_pkg;

	// Execute cycles that follow decode in every exception entry
	localparam int EX_CYCLES = 4;
	localparam logic [1:0] EX_LAST = 2'h3;

	// Access size encoding on the memory access path
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] SIZE_LONG = 2'h2;

	// On-chip peripheral register space and its byte-wide part
	localparam logic [31:0] PERIPH_LO = 32'hFFFF_0000;
	localparam logic [31:0] PERIPH_HI = 32'hFFFF_FFFF;
	localparam logic [31:0] BYTE_AREA_LO = 32'hFFFF_8000;
	localparam logic [31:0] BYTE_AREA_HI = 32'hFFFF_BFFF;

	// Translation fault vector bit positions
	localparam int TLB_MISS_BIT = 0;
	localparam int TLB_INVALID_BIT = 1;
	localparam int TLB_INIT_WRITE_BIT = 2;
	localparam int TLB_PROTECT_BIT = 3;
	localparam int TLB_KINDS = 4;

	localparam logic [3:0] LEVEL_NONE = 4'h0;

	typedef enum logic [3:0] {
		CEE_CAUSE_NONE,
		CEE_CAUSE_ADDR_FETCH,
		CEE_CAUSE_ADDR_DATA,
		CEE_CAUSE_TLB_MISS,
		CEE_CAUSE_TLB_INVALID,
		CEE_CAUSE_TLB_INIT_WRITE,
		CEE_CAUSE_TLB_PROTECT,
		CEE_CAUSE_ILL_SLOT,
		CEE_CAUSE_ILL_GENERAL,
		CEE_CAUSE_INT_NMI,
		CEE_CAUSE_INT_LEVEL,
		CEE_CAUSE_INT_PERIPH
	} cee_cause_e;

	typedef enum logic {
		CEE_ST_RUN,
		CEE_ST_EX
	} cee_state_e;

endpackage

// *** cee_addr_check.sv ***
`timescale 1ns/1ns
module cee_addr_check (
	input wire logic [31:0] i_if_addr,
	input wire logic [31:0] i_ma_addr,
	input wire logic [1:0] i_ma_size,
	output logic o_fetch_fault,
	output logic o_data_fault
);

	function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	always_comb begin
		o_fetch_fault = i_if_addr[0] || in_range(i_if_addr, cee_pkg::PERIPH_LO, cee_pkg::PERIPH_HI);
		o_data_fault = 1'b0;
		if (i_ma_size == cee_pkg::SIZE_WORD && i_ma_addr[0]) begin
			o_data_fault = 1'b1;
		end else if (i_ma_size == cee_pkg::SIZE_LONG && i_ma_addr[1:0] != 2'h0) begin
			o_data_fault = 1'b1;
		end
		if (i_ma_size == cee_pkg::SIZE_LONG &&
			in_range(i_ma_addr, cee_pkg::BYTE_AREA_LO, cee_pkg::BYTE_AREA_HI)) begin
			o_data_fault = 1'b1;
		end
	end

endmodule // cee_addr_check

// *** cee_entry.sv ***
`timescale 1ns/1ns
// What this block does
// - Interrupts are accepted in decode; later stages become the entry sequence.
// - Each entry sequence is fetch, decode, then four consecutive execute cycles.
// - Entry is not delayed: no slot instruction runs, overrun fetch still happens.
// - Handler fetch starts in the slot right after the last execute cycle.
// - Interrupt sources are non-maskable, external level lines and peripherals.
// - Address errors are taken in decode with a non-delayed overrun entry.
// - Fetch from odd address or peripheral register raises fetch address error.
// - Misaligned word or longword data access raises an address error.
// - Longword access to byte-wide peripheral area raises an address error.
// - Translation faults are taken in decode with a non-delayed overrun entry.
// - Miss, invalid, initial write and protection faults are kept distinct.
// - Illegal code taken in decode; overrun covers one or two instructions.
// - Undefined code outside a delay slot gives the general illegal exception.
// - Undefined or PC-writing code in a delay slot gives illegal-slot exception.
module cee_entry (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_nmi,
	input wire logic [3:0] i_external_level_interrupt_request,
	input wire logic [3:0] i_mask_level,
	input wire logic i_periph_irq,
	input wire logic i_if_req,
	input wire logic [31:0] i_if_addr,
	input wire logic i_ma_req,
	input wire logic [31:0] i_ma_addr,
	input wire logic [1:0] i_ma_size,
	input wire logic [3:0] i_tlb_fault,
	input wire logic i_id_valid,
	input wire logic i_id_undefined,
	input wire logic i_id_pc_write,
	input wire logic i_id_in_delay_slot,
	input wire logic i_id_two_overrun,
	output logic o_accept,
	output cee_pkg::cee_cause_e o_cause,
	output logic o_ex_active,
	output logic [1:0] o_ex_step,
	output logic o_fetch_inhibit,
	output logic o_discard,
	output logic o_handler_fetch
);

	cee_pkg::cee_state_e state_r, state_nxt;
	cee_pkg::cee_cause_e cause_r, cause_nxt, cause_pick;
	logic [1:0] step_r, step_nxt;
	logic two_r, two_nxt;
	logic handler_r, handler_nxt;
	logic fetch_err_r, fetch_err_nxt;
	logic data_err_r, data_err_nxt;
	logic [cee_pkg::TLB_KINDS-1:0] tlb_r, tlb_nxt;
	logic fetch_fault, data_fault;
	logic level_req;

	cee_addr_check u_addr_check (
		.i_if_addr(i_if_addr),
		.i_ma_addr(i_ma_addr),
		.i_ma_size(i_ma_size),
		.o_fetch_fault(fetch_fault),
		.o_data_fault(data_fault)
	);

	function automatic cee_pkg::cee_cause_e pick_cause(
		input logic fe, input logic de, input logic [3:0] tlb,
		input logic ill, input logic slot_ill, input logic nmi, input logic lvl, input logic per);
		if (fe) begin
			pick_cause = cee_pkg::CEE_CAUSE_ADDR_FETCH;
		end else if (de) begin
			pick_cause = cee_pkg::CEE_CAUSE_ADDR_DATA;
		end else if (tlb[cee_pkg::TLB_MISS_BIT]) begin
			pick_cause = cee_pkg::CEE_CAUSE_TLB_MISS;
		end else if (tlb[cee_pkg::TLB_INVALID_BIT]) begin
			pick_cause = cee_pkg::CEE_CAUSE_TLB_INVALID;
		end else if (tlb[cee_pkg::TLB_INIT_WRITE_BIT]) begin
			pick_cause = cee_pkg::CEE_CAUSE_TLB_INIT_WRITE;
		end else if (tlb[cee_pkg::TLB_PROTECT_BIT]) begin
			pick_cause = cee_pkg::CEE_CAUSE_TLB_PROTECT;
		end else if (slot_ill) begin
			pick_cause = cee_pkg::CEE_CAUSE_ILL_SLOT;
		end else if (ill) begin
			pick_cause = cee_pkg::CEE_CAUSE_ILL_GENERAL;
		end else if (nmi) begin
			pick_cause = cee_pkg::CEE_CAUSE_INT_NMI;
		end else if (lvl) begin
			pick_cause = cee_pkg::CEE_CAUSE_INT_LEVEL;
		end else if (per) begin
			pick_cause = cee_pkg::CEE_CAUSE_INT_PERIPH;
		end else begin
			pick_cause = cee_pkg::CEE_CAUSE_NONE;
		end
	endfunction

	// Level lines request above the mask
	assign level_req = (i_external_level_interrupt_request != cee_pkg::LEVEL_NONE) &&
		(i_external_level_interrupt_request > i_mask_level);

	always_comb begin
		cause_pick = pick_cause(fetch_err_r, data_err_r, tlb_r,
			i_id_undefined && !i_id_in_delay_slot,
			i_id_in_delay_slot && (i_id_undefined || i_id_pc_write),
			i_nmi, level_req, i_periph_irq);
	end

	assign o_accept = (state_r == cee_pkg::CEE_ST_RUN) && i_id_valid &&
		(cause_pick != cee_pkg::CEE_CAUSE_NONE);
	assign o_ex_active = (state_r == cee_pkg::CEE_ST_EX);
	assign o_ex_step = step_r;
	assign o_cause = cause_r;
	assign o_discard = o_ex_active;
	assign o_fetch_inhibit = o_ex_active && !(two_r && step_r == 2'h0);
	assign o_handler_fetch = handler_r;

	always_comb begin
		state_nxt = state_r;
		step_nxt = step_r;
		cause_nxt = cause_r;
		two_nxt = two_r;
		handler_nxt = 1'b0;
		case (state_r)
			cee_pkg::CEE_ST_RUN: begin
				if (o_accept) begin
					state_nxt = cee_pkg::CEE_ST_EX;
					step_nxt = 2'h0;
					cause_nxt = cause_pick;
					two_nxt = i_id_two_overrun &&
						(cause_pick == cee_pkg::CEE_CAUSE_ILL_GENERAL || cause_pick == cee_pkg::CEE_CAUSE_ILL_SLOT);
				end
			end
			cee_pkg::CEE_ST_EX: begin
				if (step_r == cee_pkg::EX_LAST) begin
					state_nxt = cee_pkg::CEE_ST_RUN;
					step_nxt = 2'h0;
					two_nxt = 1'b0;
					handler_nxt = 1'b1;
				end else begin
					step_nxt = step_r + 2'h1;
				end
			end
			default: begin
				state_nxt = cee_pkg::CEE_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_r <= cee_pkg::CEE_ST_RUN;
			step_r <= 2'h0;
			cause_r <= cee_pkg::CEE_CAUSE_NONE;
			two_r <= 1'b0;
			handler_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			step_r <= step_nxt;
			cause_r <= cause_nxt;
			two_r <= two_nxt;
			handler_r <= handler_nxt;
		end
	end

	// Pending faults: a new fault in the accept cycle survives the clear
	always_comb begin
		fetch_err_nxt = fetch_err_r;
		data_err_nxt = data_err_r;
		tlb_nxt = tlb_r;
		if (o_accept) begin
			fetch_err_nxt = 1'b0;
			data_err_nxt = 1'b0;
			tlb_nxt = '0;
		end
		if (i_if_req && !o_ex_active) begin
			fetch_err_nxt = fetch_fault;
		end
		if (i_ma_req && data_fault && !o_ex_active) begin
			data_err_nxt = 1'b1;
		end
		if (!o_ex_active) begin
			tlb_nxt = tlb_nxt | i_tlb_fault;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			fetch_err_r <= 1'b0;
			data_err_r <= 1'b0;
			tlb_r <= '0;
		end else begin
			fetch_err_r <= fetch_err_nxt;
			data_err_r <= data_err_nxt;
			tlb_r <= tlb_nxt;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	sequence s_ex_run;
		o_ex_active [*4];
	endsequence

	sequence s_ex_end;
		!o_ex_active && o_handler_fetch;
	endsequence

	chk_ex_length: assert property (o_accept |=> s_ex_run ##1 s_ex_end)
		else $error("entry sequence not four execute cycles");
	chk_handler_slot: assert property (o_handler_fetch |-> $past(o_ex_active) && $past(o_ex_step) == cee_pkg::EX_LAST)
		else $error("handler fetch not after last execute");
	chk_busy_accept: assert property (o_ex_active |-> !o_accept)
		else $error("accept during entry sequence");
	chk_overrun_discard: assert property (o_accept |=> o_discard [*4])
		else $error("overrun instruction not discarded");
	chk_single_overrun: assert property (o_accept && !i_id_two_overrun |=> o_fetch_inhibit [*4])
		else $error("extra fetch during entry");
	chk_nmi_taken: assert property (i_nmi && i_id_valid && !o_ex_active |-> o_accept ##1 o_cause != cee_pkg::CEE_CAUSE_NONE)
		else $error("non-maskable request not accepted");
	chk_slot_illegal: assert property (o_accept && fetch_err_r == 1'b0 && data_err_r == 1'b0 && tlb_r == '0 &&
		i_id_in_delay_slot && i_id_pc_write |=> o_cause == cee_pkg::CEE_CAUSE_ILL_SLOT)
		else $error("slot illegal cause wrong");
	chk_fetch_odd: assert property (i_if_req && i_if_addr[0] && !o_ex_active |=> fetch_err_r)
		else $error("odd fetch not flagged");
	chk_data_align: assert property (i_ma_req && i_ma_size == cee_pkg::SIZE_WORD && i_ma_addr[0] && !o_ex_active
		|=> data_err_r)
		else $error("misaligned word not flagged");
	chk_two_overrun: assert property (o_accept && i_id_two_overrun && i_id_undefined && !i_id_in_delay_slot &&
		!fetch_err_r && !data_err_r && tlb_r == '0 |=> !o_fetch_inhibit ##1 o_fetch_inhibit [*3])
		else $error("second overrun fetch missing");

endmodule // cee_entry

// *** cee_far_model.sv ***
`timescale 1ns/1ns
module cee_far_model (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_accept,
	input wire logic i_set_nmi,
	input wire logic [3:0] i_set_level,
	input wire logic i_set_periph,
	input wire logic [3:0] i_set_tlb,
	output logic o_nmi,
	output logic [3:0] o_level,
	output logic o_periph,
	output logic [3:0] o_tlb_fault
);
	// Three held sources
	// Requests stay up until the core acknowledges an entry
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_nmi <= 1'h0;
			o_level <= 4'h0;
			o_periph <= 1'h0;
		end else if (i_accept) begin
			o_nmi <= 1'h0;
			o_level <= 4'h0;
			o_periph <= 1'h0;
		end else begin
			o_nmi <= o_nmi | i_set_nmi;
			o_level <= (i_set_level != 4'h0) ? i_set_level : o_level;
			o_periph <= o_periph | i_set_periph;
		end
	end
	assign o_tlb_fault = i_set_tlb;
endmodule // cee_far_model

// *** cee_entry_tb.sv ***
`timescale 1ns/1ns
module cee_entry_tb;
	typedef struct {logic [31:0] ia; logic mr; logic [31:0] ma; logic [1:0] sz; logic [3:0] tlb; logic [3:0] f;
		logic [3:0] lv; logic [3:0] mk; logic nm; logic pe; cee_pkg::cee_cause_e c;} cee_row_s;
	logic i_clk = 1'h0, i_reset_n = 1'h0, i_if_req = 1'h0, i_ma_req = 1'h0, i_id_valid = 1'h0;
	logic [31:0] i_if_addr = 32'h0, i_ma_addr = 32'h0;
	logic [1:0] i_ma_size = 2'h0;
	logic [3:0] i_mask_level = 4'h0, sl = 4'h0, st = 4'h0;
	logic i_id_undefined = 1'h0, i_id_pc_write = 1'h0, i_id_in_delay_slot = 1'h0, i_id_two_overrun = 1'h0;
	logic sn = 1'h0, sp = 1'h0, i_nmi, i_periph_irq, o_accept, o_ex_active, o_fetch_inhibit, o_discard, o_handler_fetch;
	logic [3:0] i_external_level_interrupt_request, i_tlb_fault;
	logic [1:0] o_ex_step;
	cee_pkg::cee_cause_e o_cause;
	int miscompares = 0, n_tests = 0;
	cee_row_s rows[18];
	cee_entry dut (.i_clk, .i_reset_n, .i_nmi, .i_external_level_interrupt_request, .i_mask_level, .i_periph_irq,
		.i_if_req, .i_if_addr, .i_ma_req, .i_ma_addr, .i_ma_size, .i_tlb_fault, .i_id_valid, .i_id_undefined,
		.i_id_pc_write, .i_id_in_delay_slot, .i_id_two_overrun, .o_accept, .o_cause, .o_ex_active, .o_ex_step,
		.o_fetch_inhibit, .o_discard, .o_handler_fetch);
	cee_far_model far (.i_clk, .i_reset_n, .i_accept(o_accept), .i_set_nmi(sn), .i_set_level(sl), .i_set_periph(sp),
		.i_set_tlb(st), .o_nmi(i_nmi), .o_level(i_external_level_interrupt_request), .o_periph(i_periph_irq),
		.o_tlb_fault(i_tlb_fault));
	initial begin
		forever #25 i_clk = ~i_clk;
	end
	task automatic chk_v(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic chk_c(input cee_pkg::cee_cause_e got, input cee_pkg::cee_cause_e exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t cause got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic tick;
		@(posedge i_clk);
		#5;
	endtask
	// Walks the four execute cycles and the handler fetch slot
	task automatic ex_seq(input cee_pkg::cee_cause_e c, input logic two);
		for (int k = 0; k < 4; k++) begin
			chk_v(o_ex_active, 1'h1, "active");
			chk_v(o_ex_step, k, "step");
			chk_v(o_fetch_inhibit, !(k == 0 && two), "inhibit");
			chk_v(o_discard, 1'h1, "discard");
			chk_v(o_handler_fetch, 1'h0, "early handler");
			chk_c(o_cause, c);
			tick();
		end
		chk_v(o_ex_active, 1'h0, "active end");
		chk_v(o_handler_fetch, 1'h1, "handler");
	endtask
	task automatic run(input cee_row_s r);
		tick();
		{i_if_req, i_if_addr, i_ma_req, i_ma_addr, i_ma_size} = {1'h1, r.ia, r.mr, r.ma, r.sz};
		{st, sn, sl, sp, i_mask_level} = {r.tlb, r.nm, r.lv, r.pe, r.mk};
		tick();
		{i_if_req, i_ma_req, st, sn, sl, sp} = '0;
		i_id_valid = 1'h1;
		{i_id_undefined, i_id_pc_write, i_id_in_delay_slot, i_id_two_overrun} = r.f;
		#40 chk_v(o_accept, r.c != cee_pkg::CEE_CAUSE_NONE, "accept");
		tick();
		i_id_valid = 1'h0;
		{i_id_undefined, i_id_pc_write, i_id_in_delay_slot, i_id_two_overrun} = 4'h0;
		if (r.c != cee_pkg::CEE_CAUSE_NONE) ex_seq(r.c, r.f[0]);
	endtask
	initial begin
		repeat (5000) @(posedge i_clk);
		miscompares++;
		test_done();
	end
	initial begin
		rows = '{'{32'h0000_1001, '0, '0, '0, '0, '0, '0, '0, '0, '0, cee_pkg::CEE_CAUSE_ADDR_FETCH},
			'{32'hFFFF_0010, '0, '0, '0, '0, '0, '0, '0, '0, '0, cee_pkg::CEE_CAUSE_ADDR_FETCH},
			'{32'h1000, '1, 32'h2001, 2'h1, '0, '0, '0, '0, '0, '0, cee_pkg::CEE_CAUSE_ADDR_DATA},
			'{32'h1000, '1, 32'h2002, 2'h2, '0, '0, '0, '0, '0, '0, cee_pkg::CEE_CAUSE_ADDR_DATA},
			'{32'h1000, '1, 32'hFFFF_8000, 2'h2, '0, '0, '0, '0, '0, '0, cee_pkg::CEE_CAUSE_ADDR_DATA},
			'{32'h1000, '1, 32'h2001, 2'h0, '0, 4'h4, '0, '0, '0, '0, cee_pkg::CEE_CAUSE_NONE},
			'{32'h1000, '0, '0, '0, 4'h1, '0, '0, '0, '0, '0, cee_pkg::CEE_CAUSE_TLB_MISS},
			'{32'h1000, '0, '0, '0, 4'h2, '0, '0, '0, '0, '0, cee_pkg::CEE_CAUSE_TLB_INVALID},
			'{32'h1000, '0, '0, '0, 4'h4, '0, '0, '0, '0, '0, cee_pkg::CEE_CAUSE_TLB_INIT_WRITE},
			'{32'h1000, '0, '0, '0, 4'h8, '0, '0, '0, '0, '0, cee_pkg::CEE_CAUSE_TLB_PROTECT},
			'{32'h1000, '0, '0, '0, '0, 4'hA, '0, '0, '0, '0, cee_pkg::CEE_CAUSE_ILL_SLOT},
			'{32'h1000, '0, '0, '0, '0, 4'h6, '0, '0, '0, '0, cee_pkg::CEE_CAUSE_ILL_SLOT},
			'{32'h1000, '0, '0, '0, '0, 4'h8, '0, '0, '0, '0, cee_pkg::CEE_CAUSE_ILL_GENERAL},
			'{32'h1000, '0, '0, '0, '0, 4'h9, '0, '0, '0, '0, cee_pkg::CEE_CAUSE_ILL_GENERAL},
			'{32'h1000, '0, '0, '0, '0, '0, '0, '0, '1, '0, cee_pkg::CEE_CAUSE_INT_NMI},
			'{32'h1000, '0, '0, '0, '0, '0, 4'h5, 4'h3, '0, '0, cee_pkg::CEE_CAUSE_INT_LEVEL},
			'{32'h1000, '0, '0, '0, '0, '0, 4'h3, 4'h3, '0, '1, cee_pkg::CEE_CAUSE_INT_PERIPH},
			'{32'h0000_1001, '0, '0, '0, 4'h1, '0, '0, '0, '1, '0, cee_pkg::CEE_CAUSE_ADDR_FETCH}};
		repeat (8) @(posedge i_clk);
		chk_v({o_accept, o_ex_active, o_handler_fetch, o_discard}, 4'h0, "reset outputs");
		chk_c(o_cause, cee_pkg::CEE_CAUSE_NONE);
		#5 i_reset_n = 1'h1;
		foreach (rows[i]) run(rows[i]);
		// Entry while decode stays valid: refusal during execute, then back-to-back accept
		tick();
		sn = 1'h1;
		tick();
		sn = 1'h0;
		i_id_valid = 1'h1;
		#40 chk_v(o_accept, 1'h1, "nmi accept");
		tick();
		{sp, st} = 5'h11;
		for (int k = 0; k < 4; k++) begin
			#40 chk_v(o_accept, 1'h0, "accept in execute");
			tick();
			{sp, st} = 5'h0;
		end
		#40 chk_v({o_accept, o_handler_fetch}, 2'h3, "back to back");
		tick();
		i_id_valid = 1'h0;
		ex_seq(cee_pkg::CEE_CAUSE_INT_PERIPH, 1'h0);
		// Reset in mid entry clears the sequence
		run(rows[14]);
		tick();
		sn = 1'h1;
		tick();
		sn = 1'h0;
		i_id_valid = 1'h1;
		tick();
		i_id_valid = 1'h0;
		tick();
		i_reset_n = 1'h0;
		#10 chk_v({o_ex_active, o_discard, o_fetch_inhibit, o_handler_fetch}, 4'h0, "mid reset");
		chk_c(o_cause, cee_pkg::CEE_CAUSE_NONE);
		tick();
		i_reset_n = 1'h1;
		// Quiet on the first edge after release, then a fresh entry runs in full
		tick();
		chk_v({o_accept, o_ex_active, o_handler_fetch, o_fetch_inhibit}, 4'h0, "after reset");
		run(rows[12]);
		test_done();
	end
endmodule // cee_entry_tb
